// *** logic/i2cs_consts.svh ***
`ifndef I2CS_CONSTS_SVH
`define I2CS_CONSTS_SVH
`define I2CS_ADDR_HI 5'h12
`define I2CS_MCODE_HI 5'h01
`define I2CS_BITS_PER_BYTE 4'h8
`define I2CS_REF_HZ 10000000
`define I2CS_SCL_HZ 100000
`define I2CS_HALF_DIV ((`I2CS_REF_HZ / `I2CS_SCL_HZ) / 4)
`define I2CS_DIV_W 8
`endif

// *** logic/i2cs_pkg.sv ***
package i2cs_pkg;
  typedef enum logic [4:0] {
    I2CS_IDLE = 5'h01,
    I2CS_ADDR = 5'h02,
    I2CS_RECV = 5'h04,
    I2CS_SEND = 5'h08,
    I2CS_ACK = 5'h10
  } i2cs_state_t;
  typedef enum logic [5:0] {
    I2CM_IDLE = 6'h01,
    I2CM_START = 6'h02,
    I2CM_BIT = 6'h04,
    I2CM_ACKB = 6'h08,
    I2CM_STOP = 6'h10,
    I2CM_DONE = 6'h20
  } i2cm_state_t;
endpackage

// *** logic/i2cs_bus_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface i2cs_bus_if;
  logic scl_o;
  logic scl_oe_n;
  logic sda_dev_o;
  logic sda_dev_oe_n;
  logic sda_host_o;
  logic sda_host_oe_n;
  logic scl;
  logic sda;
  modport device (
    input scl,
    input sda,
    output sda_dev_o,
    output sda_dev_oe_n
  );
  modport host (
    input scl,
    input sda,
    output scl_o,
    output scl_oe_n,
    output sda_host_o,
    output sda_host_oe_n
  );
endinterface
`default_nettype wire

// *** logic/i2cs_device.sv ***
// Summary of operation
// - master starts only when bus idle
// - SDA fall with SCL high is START
// - SDA rise with SCL high is STOP
// - SDA changes only while SCL low
// - eight bits plus acknowledge per byte
// - acknowledge address match and written bytes
// - acknowledge holds SDA low through clock high
// - master NAKs last read byte
// - after NAK slave releases SDA
// - byte count set only by master
// - master makes all clocks and conditions
// - repeated START restarts address reception
// - address is 10010 plus two strap bits
// - strap pins captured once after reset
// - last address bit selects direction
// - address latched on falling SCL edge
// - read transfers shift bytes out
// - master code 00001xxx enters high speed
// - master code never acknowledged
// - high speed held until STOP
// - runs at the 100 kHz SCL that the host makes from a 10 MHz reference, also in high speed mode
`timescale 1ns/1ps
`default_nettype none
`include "i2cs_consts.svh"
module i2cs_device
  import i2cs_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rstn,
  i2cs_bus_if.device bus,
  input wire logic addr_select_hi_pin,
  input wire logic addr_select_lo_pin,
  input wire logic [7:0] tx_byte,
  output logic tx_take,
  output logic [7:0] rx_byte,
  output logic rx_valid,
  output logic selected,
  output logic read_mode,
  output logic high_speed_mode
);
  typedef struct packed {
    i2cs_state_t st;
    logic [1:0] scl_s;
    logic [1:0] sda_s;
    logic scl_p;
    logic sda_p;
    logic [1:0] strap;
    logic [1:0] strap_m;
    logic [1:0] strap_s;
    logic [1:0] strap_age;
    logic strap_done;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic rd;
    logic acking;
    logic mack;
    logic sda_oe_n;
    logic hs;
    logic hs_arm;
    logic sel;
    logic [7:0] rxb;
    logic rxv;
    logic take;
  } i2cs_dev_t;
  i2cs_dev_t q, d;
  logic scl_rise, scl_fall, start_c, stop_c;
  always_comb begin
    d = q;
    d.scl_s = {q.scl_s[0], bus.scl};
    d.sda_s = {q.sda_s[0], bus.sda};
    d.scl_p = q.scl_s[1];
    d.sda_p = q.sda_s[1];
    d.rxv = 1'b0;
    d.take = 1'b0;
    scl_rise = q.scl_s[1] & ~q.scl_p;
    scl_fall = ~q.scl_s[1] & q.scl_p;
    start_c = q.scl_s[1] & q.scl_p & q.sda_p & ~q.sda_s[1];
    stop_c = q.scl_s[1] & q.scl_p & ~q.sda_p & q.sda_s[1];
    // straps pass two flops, then are frozen once
    d.strap_m = {addr_select_hi_pin, addr_select_lo_pin};
    d.strap_s = q.strap_m;
    if (!q.strap_done) begin
      if (q.strap_age == 2'h2) begin
        d.strap = q.strap_s;
        d.strap_done = 1'b1;
      end else begin
        d.strap_age = q.strap_age + 2'h1;
      end
    end
    if (stop_c) begin
      d.st = I2CS_IDLE;
      d.sda_oe_n = 1'b1;
      d.hs = 1'b0;
      d.hs_arm = 1'b0;
      d.sel = 1'b0;
    end else if (start_c) begin
      d.st = I2CS_ADDR;
      d.cnt = 4'h0;
      d.hs_arm = 1'b0;
      d.sda_oe_n = 1'b1;
      d.sel = 1'b0;
    end else begin
      unique case (q.st)
        I2CS_IDLE: begin
          d.sda_oe_n = 1'b1;
          // high speed only once the ninth clock shows a nak
          if (q.hs_arm && scl_rise) begin
            d.hs_arm = 1'b0;
            d.hs = q.hs | q.sda_s[1];
          end
        end
        I2CS_ADDR, I2CS_RECV: begin
          if (scl_rise) begin
            d.sh = {q.sh[6:0], q.sda_s[1]};
            d.cnt = q.cnt + 4'h1;
          end
          if (scl_fall && q.cnt == `I2CS_BITS_PER_BYTE) begin
            d.cnt = 4'h0;
            if (q.st == I2CS_ADDR) begin
              d.rd = q.sh[0];
              if (q.sh[7:3] == `I2CS_MCODE_HI) begin
                d.hs_arm = 1'b1;
                d.st = I2CS_IDLE;
              end else if (q.sh[7:1] == {`I2CS_ADDR_HI, q.strap}) begin
                d.sel = 1'b1;
                d.acking = 1'b1;
                d.sda_oe_n = 1'b0;
                d.st = I2CS_ACK;
              end else begin
                d.st = I2CS_IDLE;
              end
            end else begin
              d.rxb = q.sh;
              d.rxv = 1'b1;
              d.acking = 1'b1;
              d.sda_oe_n = 1'b0;
              d.st = I2CS_ACK;
            end
          end
        end
        I2CS_ACK: begin
          if (q.acking) begin
            if (scl_fall) begin
              d.acking = 1'b0;
              if (q.rd) begin
                d.sh = tx_byte;
                d.take = 1'b1;
                d.sda_oe_n = tx_byte[7];
                d.cnt = 4'h1;
                d.st = I2CS_SEND;
              end else begin
                d.sda_oe_n = 1'b1;
                d.st = I2CS_RECV;
              end
            end
          end else begin
            if (scl_rise) begin
              d.mack = ~q.sda_s[1];
            end
            if (scl_fall) begin
              if (q.mack) begin
                d.sh = tx_byte;
                d.take = 1'b1;
                d.sda_oe_n = tx_byte[7];
                d.cnt = 4'h1;
                d.st = I2CS_SEND;
              end else begin
                d.sda_oe_n = 1'b1;
                d.st = I2CS_IDLE;
              end
            end
          end
        end
        I2CS_SEND: begin
          if (scl_fall) begin
            if (q.cnt == `I2CS_BITS_PER_BYTE) begin
              d.sda_oe_n = 1'b1;
              d.st = I2CS_ACK;
            end else begin
              d.sh = {q.sh[6:0], 1'b0};
              d.sda_oe_n = q.sh[6];
              d.cnt = q.cnt + 4'h1;
            end
          end
        end
        default: d.st = I2CS_IDLE;
      endcase
    end
  end
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      q <= '0;
      q.st <= I2CS_IDLE;
      q.scl_s <= 2'h3;
      q.sda_s <= 2'h3;
      q.scl_p <= 1'b1;
      q.sda_p <= 1'b1;
      q.sda_oe_n <= 1'b1;
    end else begin
      q <= d;
    end
  end
  assign bus.sda_dev_o = 1'b0;
  assign bus.sda_dev_oe_n = q.sda_oe_n;
  assign tx_take = q.take;
  assign rx_byte = q.rxb;
  assign rx_valid = q.rxv;
  assign selected = q.sel;
  assign read_mode = q.rd;
  assign high_speed_mode = q.hs;
endmodule
`default_nettype wire

// *** logic/i2cs_host.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "i2cs_consts.svh"
module i2cs_host
  import i2cs_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rstn,
  i2cs_bus_if.host bus,
  input wire logic cmd_valid,
  input wire logic cmd_start,
  input wire logic cmd_stop,
  input wire logic cmd_read,
  input wire logic cmd_nak,
  input wire logic [7:0] cmd_byte,
  output logic cmd_ready,
  output logic [7:0] rsp_byte,
  output logic rsp_ack,
  output logic rsp_valid
);
  typedef struct packed {
    i2cm_state_t st;
    logic [1:0] scl_s;
    logic [1:0] sda_s;
    logic [`I2CS_DIV_W-1:0] div;
    logic [1:0] ph;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic rd;
    logic nak;
    logic stop;
    logic scl_oe_n;
    logic sda_oe_n;
    logic rdy;
    logic [7:0] rb;
    logic ack;
    logic rv;
  } i2cm_t;
  i2cm_t q, d;
  logic tick;
  always_comb begin
    d = q;
    d.scl_s = {q.scl_s[0], bus.scl};
    d.sda_s = {q.sda_s[0], bus.sda};
    d.rv = 1'b0;
    tick = (q.div == `I2CS_DIV_W'(`I2CS_HALF_DIV - 1));
    d.div = tick ? '0 : q.div + `I2CS_DIV_W'(1);
    if (q.st != I2CM_IDLE && q.st != I2CM_DONE && tick) d.ph = q.ph + 2'h1;
    unique case (q.st)
      I2CM_IDLE: begin
        d.ph = 2'h0;
        if (cmd_valid && q.rdy) begin
          d.rdy = 1'b0;
          d.sh = cmd_byte;
          d.rd = cmd_read;
          d.nak = cmd_nak;
          d.stop = cmd_stop;
          d.cnt = 4'h0;
          d.st = cmd_start ? I2CM_START : I2CM_BIT;
        end
      end
      I2CM_START: if (tick) begin
        unique case (q.ph)
          2'h0: begin d.sda_oe_n = 1'b1; d.scl_oe_n = 1'b1; end
          2'h1: if (q.scl_s[1] && q.sda_s[1]) d.sda_oe_n = 1'b0;
                else d.ph = q.ph;
          2'h2: d.scl_oe_n = 1'b0;
          2'h3: d.st = I2CM_BIT;
        endcase
      end
      I2CM_BIT, I2CM_ACKB: if (tick) begin
        unique case (q.ph)
          2'h0: begin
            if (q.st == I2CM_BIT)
              d.sda_oe_n = q.rd ? 1'b1 : q.sh[7];
            else
              d.sda_oe_n = q.rd ? q.nak : 1'b1;
          end
          2'h1: d.scl_oe_n = 1'b1;
          2'h2: begin
            if (!q.scl_s[1]) d.ph = q.ph;
            else if (q.st == I2CM_BIT) begin
              d.sh = {q.sh[6:0], q.sda_s[1]};
              d.cnt = q.cnt + 4'h1;
            end else d.ack = ~q.sda_s[1];
          end
          2'h3: begin
            d.scl_oe_n = 1'b0;
            if (q.st == I2CM_BIT) begin
              if (q.cnt == `I2CS_BITS_PER_BYTE) d.st = I2CM_ACKB;
            end else begin
              d.rb = q.sh;
              d.rv = 1'b1;
              d.st = q.stop ? I2CM_STOP : I2CM_DONE;
            end
          end
        endcase
      end
      I2CM_STOP: if (tick) begin
        unique case (q.ph)
          2'h0: d.sda_oe_n = 1'b0;
          2'h1: d.scl_oe_n = 1'b1;
          2'h2: d.sda_oe_n = 1'b1;
          2'h3: d.st = I2CM_DONE;
        endcase
      end
      I2CM_DONE: begin
        d.rdy = 1'b1;
        d.st = I2CM_IDLE;
      end
      default: d.st = I2CM_IDLE;
    endcase
  end
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      q <= '0;
      q.st <= I2CM_IDLE;
      q.scl_s <= 2'h3;
      q.sda_s <= 2'h3;
      q.scl_oe_n <= 1'b1;
      q.sda_oe_n <= 1'b1;
      q.rdy <= 1'b1;
    end else begin
      q <= d;
    end
  end
  assign bus.scl_o = 1'b0;
  assign bus.scl_oe_n = q.scl_oe_n;
  assign bus.sda_host_o = 1'b0;
  assign bus.sda_host_oe_n = q.sda_oe_n;
  assign cmd_ready = q.rdy;
  assign rsp_byte = q.rb;
  assign rsp_ack = q.ack;
  assign rsp_valid = q.rv;
endmodule
`default_nettype wire

// *** test/i2cs_bus_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
module i2cs_bus_sva (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic scl,
  input wire logic sda,
  input wire logic scl_oe_n,
  input wire logic sda_dev_oe_n,
  input wire logic sda_host_oe_n
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // scl rises since the last start, wrapping 1..9 per byte
  logic [3:0] rise_cnt_q;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rise_cnt_q <= 4'h0;
    end else if (scl && $fell(sda)) begin
      rise_cnt_q <= 4'h0;
    end else if ($rose(scl)) begin
      rise_cnt_q <= (rise_cnt_q == 4'h9) ? 4'h1 : rise_cnt_q + 4'h1;
    end
  end
  a_dev_sda_low: assert property ($changed(sda_dev_oe_n) |-> !scl)
    else $error("device moved sda while scl high");
  a_ack_hold: assert property (!sda_dev_oe_n && $rose(scl) |->
    !sda_dev_oe_n [*8])
    else $error("device released sda within clock high");
  a_one_talker: assert property (scl_oe_n |->
    sda_dev_oe_n || sda_host_oe_n)
    else $error("both ends drive sda while scl high");
  a_scl_low_min: assert property ($fell(scl) |-> !scl [*8])
    else $error("scl low phase too short");
  a_scl_high_min: assert property ($rose(scl) |-> scl [*8])
    else $error("scl high phase too short");
  a_start_hold: assert property (scl && $fell(sda) |-> scl [*8])
    else $error("scl dropped right after start");
  a_stop_idle: assert property (scl && $rose(sda) |-> sda [*8])
    else $error("bus not idle after stop");
  a_stop_free: assert property (scl && $rose(sda) |-> sda_dev_oe_n)
    else $error("device still driving at stop");
  a_byte_frame: assert property (scl && $rose(sda) |->
    rise_cnt_q == 4'h1)
    else $error("stop not after whole nine-clock bytes");
  cover property (!sda_dev_oe_n && $rose(scl));
  cover property (scl && $fell(sda));
  cover property (scl && $rose(sda));
endmodule
`default_nettype wire

// *** test/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import i2cs_pkg::*;
  logic ref_clk, rstn, hi_pin, lo_pin, cmd_valid, cmd_start, cmd_stop;
  logic cmd_read, cmd_nak, cmd_ready, rsp_ack, rsp_valid, tx_take;
  logic rx_valid, selected, read_mode, hs, pscl, psda;
  logic [7:0] cmd_byte, tx_byte, rsp_byte, rx_byte, b;
  logic [9:0] e;
  logic [9:0] expq[$];
  logic [7:0] txq[$];
  logic [7:0] rxq[$];
  logic [8:0] wsr, wlast;
  logic [3:0] wcnt;
  logic [6:0] addr;
  int failures, num_checks, cycles, i;
  integer seed;
  i2cs_bus_if bus ();
  assign bus.scl = bus.scl_oe_n | bus.scl_o;
  assign bus.sda = (bus.sda_dev_oe_n | bus.sda_dev_o) &
    (bus.sda_host_oe_n | bus.sda_host_o);
  i2cs_host i2cs_host_inst (.ref_clk(ref_clk), .rstn(rstn), .bus(bus),
    .cmd_valid(cmd_valid), .cmd_start(cmd_start), .cmd_stop(cmd_stop),
    .cmd_read(cmd_read), .cmd_nak(cmd_nak), .cmd_byte(cmd_byte),
    .cmd_ready(cmd_ready), .rsp_byte(rsp_byte), .rsp_ack(rsp_ack),
    .rsp_valid(rsp_valid));
  i2cs_device i2cs_device_inst (.ref_clk(ref_clk), .rstn(rstn), .bus(bus),
    .addr_select_hi_pin(hi_pin), .addr_select_lo_pin(lo_pin),
    .tx_byte(tx_byte), .tx_take(tx_take), .rx_byte(rx_byte),
    .rx_valid(rx_valid), .selected(selected), .read_mode(read_mode),
    .high_speed_mode(hs));
  i2cs_bus_sva i2cs_bus_sva_inst (.ref_clk(ref_clk), .rstn(rstn),
    .scl(bus.scl), .sda(bus.sda), .scl_oe_n(bus.scl_oe_n),
    .sda_dev_oe_n(bus.sda_dev_oe_n), .sda_host_oe_n(bus.sda_host_oe_n));
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  task automatic report_and_stop;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // f: start stop read nak, then expected ack
  task automatic xfer(input logic [4:0] f, input logic [7:0] d);
    expq.push_back({f[2], f[0], d});
    @(posedge ref_clk);
    #1;
    cmd_valid = 1'b1;
    {cmd_start, cmd_stop, cmd_read, cmd_nak} = f[4:1];
    cmd_byte = d;
    do @(posedge ref_clk); while (cmd_ready !== 1'b1);
    #1 cmd_valid = 1'b0;
  endtask
  task automatic drain;
    while (expq.size() != 0 || cmd_ready !== 1'b1) @(posedge ref_clk);
    repeat (4) @(posedge ref_clk);
    #1;
  endtask
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 40000) begin
      failures++;
      report_and_stop;
    end
    if (tx_take === 1'b1) begin
      txq.push_back(tx_byte);
      tx_byte <= #1 8'($random(seed));
    end
    if (rsp_valid === 1'b1) begin
      if (expq.size() == 0) begin
        chk(9'h1ff, 9'h0);
      end else begin
        e = expq.pop_front();
        chk({8'h0, rsp_ack}, {8'h0, e[8]});
        if (e[9]) chk({1'b0, rsp_byte}, {1'b0, txq.pop_front()});
        else chk({1'b0, rsp_byte}, {1'b0, e[7:0]});
      end
    end
    if (rx_valid === 1'b1) begin
      if (rxq.size() == 0) begin
        chk(9'h1ff, 9'h0);
      end else begin
        chk({1'b0, rx_byte}, {1'b0, rxq.pop_front()});
      end
    end
    pscl <= bus.scl;
    psda <= bus.sda;
    if (pscl && bus.scl && psda && !bus.sda) begin
      wcnt <= 4'h0;
    end else if (!pscl && bus.scl) begin
      wsr <= {wsr[7:0], bus.sda};
      wcnt <= (wcnt == 4'h8) ? 4'h0 : wcnt + 4'h1;
      if (wcnt == 4'h8) wlast <= {wsr[7:0], bus.sda};
    end
  end
  initial begin
    seed = 32'h14fa;
    {cmd_valid, cmd_start, cmd_stop, cmd_read, cmd_nak} = 5'h00;
    {failures, num_checks, cycles, wcnt, wsr, wlast} = '0;
    cmd_byte = 8'h00;
    pscl = 1'b1;
    psda = 1'b1;
    rstn = 1'b0;
    {hi_pin, lo_pin} = 2'($random(seed));
    tx_byte = 8'($random(seed));
    repeat (2) @(posedge ref_clk);
    #1 rstn = 1'b1;
    repeat (2) @(posedge ref_clk);
    addr = {5'h12, hi_pin, lo_pin};
    xfer(5'b10001, {addr, 1'b0});
    drain;
    chk(wlast, {addr, 2'b00});
    chk({7'h0, selected, read_mode}, 9'h2);
    for (i = 0; i < 3; i++) begin
      b = 8'($random(seed));
      rxq.push_back(b);
      xfer({1'b0, i == 2, 3'b001}, b);
    end
    drain;
    chk(9'(rxq.size()), 9'h0);
    $display("write test done");
    xfer(5'b10000, {addr ^ 7'h01, 1'b0});
    xfer(5'b01000, 8'h5a);
    drain;
    chk({8'h0, selected}, 9'h0);
    $display("mismatch test done");
    xfer(5'b10001, {addr, 1'b1});
    xfer(5'b00101, 8'h00);
    xfer(5'b01110, 8'h00);
    drain;
    chk({8'h0, bus.sda_dev_oe_n}, 9'h1);
    $display("read test done");
    {hi_pin, lo_pin} = ~{hi_pin, lo_pin};
    b = {5'h01, 3'($random(seed))};
    xfer(5'b10000, b);
    drain;
    chk(wlast, {b, 1'b1});
    chk({8'h0, hs}, 9'h1);
    xfer(5'b10001, {addr, 1'b0});
    drain;
    chk({7'h0, hs, selected}, 9'h3);
    rxq.push_back(8'h3c);
    xfer(5'b01001, 8'h3c);
    drain;
    chk({8'h0, hs}, 9'h0);
    $display("high speed test done");
    report_and_stop;
  end
endmodule
`default_nettype wire
